// ===== core/mst_chopper.sv
// Fixed off-time chopper with blanking for one full bridge
`timescale 1ns/10ps
module mst_chopper (
   input wire logic clk,
   input wire logic resetn,
   mst_wind_if.chop w
);
   mst_pkg::mst_chop_t st_reg;
   logic [15:0]        cnt_reg;
   logic [7:0]         blank_reg;
   logic [1:0]         hs_reg;
   logic [1:0]         ls_reg;
   logic [1:0]         driveHs;
   logic               tripSeen;

   // Diagonal pair follows the commanded polarity
   assign driveHs  = w.pol ? 2'h1 : 2'h2;
   // Comparator ignored while the blank counter runs
   assign tripSeen = w.trip && (blank_reg == 8'h00);
   assign w.hs     = hs_reg;
   assign w.ls     = ls_reg;

   // Chopper state, off-time counter, blank counter and gates
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg    <= mst_pkg::CH_OFF;
         cnt_reg   <= 16'h0000;
         blank_reg <= 8'h00;
         hs_reg    <= mst_pkg::GATE_NONE;
         ls_reg    <= mst_pkg::GATE_NONE;
      end else if (!w.en) begin
         // Disabled bridge: every FET off
         st_reg <= mst_pkg::CH_OFF;
         hs_reg <= mst_pkg::GATE_NONE;
         ls_reg <= mst_pkg::GATE_NONE;
      end else begin
         if (blank_reg != 8'h00) begin
            blank_reg <= blank_reg - 8'h01;
         end
         case (st_reg)
            mst_pkg::CH_OFF: begin
               st_reg    <= mst_pkg::CH_ON;
               hs_reg    <= driveHs;
               ls_reg    <= ~driveHs;
               blank_reg <= mst_pkg::BLANK_INIT;
            end
            mst_pkg::CH_ON: begin
               hs_reg <= driveHs;
               ls_reg <= ~driveHs;
               if (tripSeen) begin
                  cnt_reg   <= w.offCyc - 16'h0001;
                  blank_reg <= mst_pkg::BLANK_INIT;
                  if (w.mixed) begin
                     // Reverse diagonal drives current down fast
                     st_reg <= mst_pkg::CH_FAST;
                     hs_reg <= ~driveHs;
                     ls_reg <= driveHs;
                  end else begin
                     // Source off, sinks recirculate
                     st_reg <= mst_pkg::CH_SLOW;
                     hs_reg <= mst_pkg::GATE_NONE;
                     ls_reg <= mst_pkg::GATE_BOTH;
                  end
               end
            end
            mst_pkg::CH_FAST: begin
               cnt_reg <= cnt_reg - 16'h0001;
               if (cnt_reg <= w.slowCyc) begin
                  st_reg    <= mst_pkg::CH_SLOW;
                  hs_reg    <= mst_pkg::GATE_NONE;
                  ls_reg    <= mst_pkg::GATE_BOTH;
                  blank_reg <= mst_pkg::BLANK_INIT;
               end
            end
            default: begin
               cnt_reg <= cnt_reg - 16'h0001;
               if (cnt_reg == 16'h0000) begin
                  st_reg    <= mst_pkg::CH_ON;
                  hs_reg    <= driveHs;
                  ls_reg    <= ~driveHs;
                  blank_reg <= mst_pkg::BLANK_INIT;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   AST_DIS_OFF: assert property (!w.en |=> w.hs == 2'h0 && w.ls == 2'h0)
      else $error("bridge driven while disabled");
   AST_SLOW_TRIP: assert property (st_reg == mst_pkg::CH_ON && tripSeen && w.en
      && !w.mixed |=> w.hs == 2'h0 && w.ls == 2'h3 && st_reg == mst_pkg::CH_SLOW)
      else $error("slow trip did not drop source");
   AST_MIXED_TRIP: assert property (st_reg == mst_pkg::CH_ON && tripSeen && w.en
      && w.mixed |=> st_reg == mst_pkg::CH_FAST)
      else $error("mixed trip did not enter fast decay");
   AST_BLANK_HOLD: assert property (st_reg == mst_pkg::CH_ON && blank_reg != 8'h00
      && w.en |=> st_reg == mst_pkg::CH_ON)
      else $error("trip accepted during blanking");
   AST_BLANK_LOAD: assert property ($changed(st_reg) && st_reg != mst_pkg::CH_OFF
      |-> blank_reg == mst_pkg::BLANK_INIT)
      else $error("blank not reloaded on switching");
   AST_SLOW_END: assert property (st_reg == mst_pkg::CH_SLOW && cnt_reg == 16'h0000
      && w.en |=> st_reg == mst_pkg::CH_ON)
      else $error("off-time end missed");
endmodule

// ===== core/mst_pkg.sv
// Constants and types shared by the microstep translator and chopper
package mst_pkg;
   // Clock and timing
   localparam int CLK_NS      = 4;
   localparam int NS_PER_US   = 1000;
   localparam int CYC_PER_US  = NS_PER_US / CLK_NS;
   localparam int BLANK_NS    = 1000;
   localparam int BLANK_CYC   = (BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int OFF_NS      = 30000;
   localparam int OFF_CYC_DEF = OFF_NS / CLK_NS;
   localparam logic [7:0] BLANK_INIT = 8'(BLANK_CYC - 1);
   // Fast share of a mixed off-time: 5/16 = 31.25 percent
   localparam int FAST_NUM   = 5;
   localparam int FAST_SHIFT = 4;

   // Translator position, sixteenth steps over one electrical cycle
   localparam logic [5:0] HOME_POS      = 6'h08;
   localparam logic [5:0] QUARTER_TURN  = 6'h10;
   localparam logic [5:0] INC_FULL      = 6'h10;
   localparam logic [5:0] INC_HALF      = 6'h08;
   localparam logic [5:0] INC_QUARTER   = 6'h04;
   localparam logic [5:0] INC_SIXTEENTH = 6'h01;
   localparam logic [4:0] QUAD_SPAN     = 5'h10;

   // Resolution code is {resolution_sel_hi, resolution_sel_lo}
   localparam logic [1:0] RES_FULL      = 2'h0;
   localparam logic [1:0] RES_HALF      = 2'h1;
   localparam logic [1:0] RES_QUARTER   = 2'h2;
   localparam logic [1:0] RES_SIXTEENTH = 2'h3;

   // Off-time configuration of the offtime_setting_pin
   localparam logic [1:0] OFFM_PIN_HIGH = 2'h0;
   localparam logic [1:0] OFFM_GROUND   = 2'h1;
   localparam logic [1:0] OFFM_RESISTOR = 2'h2;

   // APB register map and reset values
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_OFFUS  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_LEVEL  = 8'h0c;
   localparam logic [1:0] CTRL_RST    = 2'h0;
   localparam logic [7:0] OFFUS_RST   = 8'h1e;

   // Bridge gate patterns
   localparam logic [1:0] GATE_NONE = 2'h0;
   localparam logic [1:0] GATE_BOTH = 2'h3;

   typedef enum logic [1:0] {CH_OFF, CH_ON, CH_FAST, CH_SLOW} mst_chop_t;
endpackage

// ===== core/mst_translator.sv
// Microstep translator top with APB registers and two winding choppers
//
// What this block does
// - Step rising edge advances position, levels, polarity
// - Select pins give full, half, quarter, sixteenth
// - Resolution sampled only at step rising edge
// - Direction sampled only at step rising edge
// - Reset holds Home, bridges off, steps ignored
// - Reset loads Home levels and Mixed decay
// - Falling level picks Mixed, else Slow
// - Thermal or overcurrent returns position to Home
// - Drive diagonal, trip drops source or both
// - Pin high: 30 us, auto, full Slow
// - Ground: 30 us, always Mixed, full Slow
// - Resistor: off-time R/825 us, auto everywhere
// - Comparator blanked about 1 us after switching
// - Level code scales trip of full-scale threshold
// - Mixed decay: fast 31.25 percent, then slow
// - Enable high turns bridges off, translator runs
// - Undervoltage lockout disables bridges, resets to Home
`timescale 1ns/10ps
module mst_translator #(
   parameter int unsigned OFF_CYCLES = mst_pkg::OFF_CYC_DEF
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        stepPin,
   input  wire logic        dirPin,
   input  wire logic        resolutionSelLo,
   input  wire logic        resolutionSelHi,
   input  wire logic        translatorResetN,
   input  wire logic        outputEnableN,
   input  wire logic        thermalShutdown,
   input  wire logic        overcurrent,
   input  wire logic        undervoltageLockout,
   input  wire logic        senseTripA,
   input  wire logic        senseTripB,
   output logic [1:0]       sourceGateA,
   output logic [1:0]       sinkGateA,
   output logic [1:0]       sourceGateB,
   output logic [1:0]       sinkGateB,
   output logic [7:0]       dacLevelA,
   output logic [7:0]       dacLevelB,
   output logic             polarityA,
   output logic             polarityB,
   output logic             mixedDecayA,
   output logic             mixedDecayB
);
   // Magnitude of sine over one quadrant, 255 is full trip current
   function automatic logic [7:0] sinMag(input logic [4:0] k);
      case (k)
         5'h00:   sinMag = 8'h00;
         5'h01:   sinMag = 8'h19;
         5'h02:   sinMag = 8'h32;
         5'h03:   sinMag = 8'h4a;
         5'h04:   sinMag = 8'h62;
         5'h05:   sinMag = 8'h78;
         5'h06:   sinMag = 8'h8e;
         5'h07:   sinMag = 8'ha2;
         5'h08:   sinMag = 8'hb4;
         5'h09:   sinMag = 8'hc5;
         5'h0a:   sinMag = 8'hd4;
         5'h0b:   sinMag = 8'he1;
         5'h0c:   sinMag = 8'hec;
         5'h0d:   sinMag = 8'hf4;
         5'h0e:   sinMag = 8'hfa;
         5'h0f:   sinMag = 8'hfe;
         default: sinMag = 8'hff;
      endcase
   endfunction

   // Polarity and level of one winding at a position
   function automatic logic [8:0] windLvl(input logic [5:0] p);
      logic [4:0] idx;
      idx = {1'b0, p[3:0]};
      if (p[4]) begin
         idx = mst_pkg::QUAD_SPAN - idx;
      end
      windLvl = {~p[5], sinMag(idx)};
   endfunction

   // Decay choice for one winding at a step
   function automatic logic pickMixed(input logic [7:0] newLvl,
                                      input logic [7:0] oldLvl,
                                      input logic [1:0] mode,
                                      input logic [1:0] res);
      if (res == mst_pkg::RES_FULL && mode != mst_pkg::OFFM_RESISTOR) begin
         pickMixed = 1'b0;
      end else if (mode == mst_pkg::OFFM_GROUND) begin
         pickMixed = 1'b1;
      end else begin
         pickMixed = newLvl < oldLvl;
      end
   endfunction

   localparam int NSYNC = 11;

   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   logic             stepPrev_reg;
   logic [5:0]       pos_reg;
   logic [1:0]       resApplied_reg;
   logic [7:0]       lvlA_reg;
   logic [7:0]       lvlB_reg;
   logic             polA_reg;
   logic             polB_reg;
   logic             mixedA_reg;
   logic             mixedB_reg;
   logic [1:0]       offMode_reg;
   logic [7:0]       offUs_reg;
   logic [31:0]      prdata_reg;
   logic             stepS;
   logic             dirS;
   logic             resetNS;
   logic             enableNS;
   logic             tsdS;
   logic             ocS;
   logic             uvloS;
   logic             tripAS;
   logic             tripBS;
   logic [1:0]       resNow;
   logic             stepRise;
   logic             holdHome;
   logic             bridgeEn;
   logic [5:0]       incNow;
   logic [5:0]       newPos;
   logic [8:0]       newA;
   logic [8:0]       newB;
   logic [15:0]      offCyc;
   logic [15:0]      fastCyc;
   logic [31:0]      rdData;
   logic             addrHit;

   // Two-stage synchroniser for every pin; only stage two is read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {stepPin, dirPin, resolutionSelHi, resolutionSelLo,
                       translatorResetN, outputEnableN, thermalShutdown,
                       overcurrent, undervoltageLockout, senseTripA, senseTripB};
         sync2_reg <= sync1_reg;
      end
   end

   assign {stepS, dirS, resNow, resetNS, enableNS, tsdS, ocS, uvloS,
           tripAS, tripBS} = sync2_reg;

   // Step edge detector on the synchronised pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stepPrev_reg <= 1'b0;
      end else begin
         stepPrev_reg <= stepS;
      end
   end

   assign stepRise = stepS && !stepPrev_reg;
   // Pin reset, faults and lockout all pin the translator at Home
   assign holdHome = !resetNS || tsdS || ocS || uvloS;
   assign bridgeEn = !holdHome && !enableNS;

   // Increment chosen from resolution sampled at this edge
   always_comb begin
      case (resNow)
         mst_pkg::RES_FULL:    incNow = mst_pkg::INC_FULL;
         mst_pkg::RES_HALF:    incNow = mst_pkg::INC_HALF;
         mst_pkg::RES_QUARTER: incNow = mst_pkg::INC_QUARTER;
         default:              incNow = mst_pkg::INC_SIXTEENTH;
      endcase
   end

   // Position wraps naturally in six bits
   assign newPos = dirS ? pos_reg + incNow : pos_reg - incNow;
   assign newA   = windLvl(newPos);
   // Second winding leads by a quarter cycle
   assign newB   = windLvl(newPos + mst_pkg::QUARTER_TURN);

   // Translator position, levels, polarities and decay
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pos_reg        <= mst_pkg::HOME_POS;
         resApplied_reg <= mst_pkg::RES_FULL;
         lvlA_reg       <= 8'hb4;
         lvlB_reg       <= 8'hb4;
         polA_reg       <= 1'b1;
         polB_reg       <= 1'b1;
         mixedA_reg     <= 1'b1;
         mixedB_reg     <= 1'b1;
      end else if (holdHome) begin
         // Steps ignored while held; Home loads Mixed decay
         pos_reg    <= mst_pkg::HOME_POS;
         {polA_reg, lvlA_reg} <= windLvl(mst_pkg::HOME_POS);
         {polB_reg, lvlB_reg} <= windLvl(mst_pkg::HOME_POS + mst_pkg::QUARTER_TURN);
         mixedA_reg <= 1'b1;
         mixedB_reg <= 1'b1;
      end else if (stepRise) begin
         // Direction and resolution are only looked at here
         pos_reg        <= newPos;
         resApplied_reg <= resNow;
         {polA_reg, lvlA_reg} <= newA;
         {polB_reg, lvlB_reg} <= newB;
         mixedA_reg <= pickMixed(newA[7:0], lvlA_reg, offMode_reg, resNow);
         mixedB_reg <= pickMixed(newB[7:0], lvlB_reg, offMode_reg, resNow);
      end
   end

   // Off-time: fixed internal value, or resistor setting in microseconds
   always_comb begin
      if (offMode_reg == mst_pkg::OFFM_RESISTOR) begin
         offCyc = 16'(offUs_reg * mst_pkg::CYC_PER_US);
      end else begin
         offCyc = 16'(OFF_CYCLES);
      end
   end

   // Fast share truncates; slow decay takes the remainder
   assign fastCyc = 16'((32'(offCyc) * mst_pkg::FAST_NUM) >> mst_pkg::FAST_SHIFT);

   mst_wind_if windA ();
   mst_wind_if windB ();

   // Steering of both choppers
   assign windA.en      = bridgeEn;
   assign windA.mixed   = mixedA_reg;
   assign windA.pol     = polA_reg;
   assign windA.trip    = tripAS;
   assign windA.offCyc  = offCyc;
   assign windA.slowCyc = offCyc - fastCyc;
   assign windB.en      = bridgeEn;
   assign windB.mixed   = mixedB_reg;
   assign windB.pol     = polB_reg;
   assign windB.trip    = tripBS;
   assign windB.offCyc  = offCyc;
   assign windB.slowCyc = offCyc - fastCyc;

   mst_chopper chopA (
      .clk    (clk),
      .resetn (resetn),
      .w      (windA)
   );

   mst_chopper chopB (
      .clk    (clk),
      .resetn (resetn),
      .w      (windB)
   );

   // Pin outputs; comparator threshold is level code of full scale
   assign sourceGateA = windA.hs;
   assign sinkGateA   = windA.ls;
   assign sourceGateB = windB.hs;
   assign sinkGateB   = windB.ls;
   assign dacLevelA   = lvlA_reg;
   assign dacLevelB   = lvlB_reg;
   assign polarityA   = polA_reg;
   assign polarityB   = polB_reg;
   assign mixedDecayA = mixedA_reg;
   assign mixedDecayB = mixedB_reg;

   // Register read decode; unmapped addresses flag an error
   always_comb begin
      rdData  = 32'h0000_0000;
      addrHit = 1'b1;
      if (paddr == mst_pkg::ADDR_CTRL) begin
         rdData = {30'h0, offMode_reg};
      end else if (paddr == mst_pkg::ADDR_OFFUS) begin
         rdData = {24'h0, offUs_reg};
      end else if (paddr == mst_pkg::ADDR_STATUS) begin
         rdData = {20'h0, resApplied_reg, !bridgeEn, holdHome, mixedB_reg,
                   mixedA_reg, pos_reg};
      end else if (paddr == mst_pkg::ADDR_LEVEL) begin
         rdData = {14'h0, polB_reg, polA_reg, lvlB_reg, lvlA_reg};
      end else begin
         addrHit = 1'b0;
      end
   end

   // Read data captured in the setup cycle, ready in the access cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_reg <= rdData;
      end
   end

   // Software configuration; write takes effect on the access edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         offMode_reg <= mst_pkg::CTRL_RST;
         offUs_reg   <= mst_pkg::OFFUS_RST;
      end else if (psel && penable && pwrite) begin
         if (paddr == mst_pkg::ADDR_CTRL) begin
            offMode_reg <= pwdata[1:0];
         end else if (paddr == mst_pkg::ADDR_OFFUS) begin
            offUs_reg <= pwdata[7:0];
         end
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addrHit;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   AST_HOME_HELD: assert property (holdHome |=> pos_reg == 6'h08)
      else $error("position left Home while held");
   AST_HOME_MIXED: assert property (holdHome |=> mixedA_reg && mixedB_reg
      && lvlA_reg == 8'hb4 && lvlB_reg == 8'hb4)
      else $error("Home levels or decay wrong");
   AST_NO_STEP: assert property (!stepRise |=> $stable(pos_reg) || $past(holdHome))
      else $error("position moved without a step");
   AST_FWD_FULL: assert property (stepRise && !holdHome && dirS
      && resNow == 2'h0 |=> pos_reg == 6'($past(pos_reg) + 6'h10))
      else $error("full forward step wrong");
   AST_REV_SIXT: assert property (stepRise && !holdHome && !dirS
      && resNow == 2'h3 |=> pos_reg == 6'($past(pos_reg) - 6'h01))
      else $error("sixteenth reverse step wrong");
   AST_FULL_SLOW: assert property (stepRise && !holdHome && resNow == 2'h0
      && offMode_reg != 2'h2 |=> !mixedA_reg && !mixedB_reg)
      else $error("full step not slow decay");
   AST_GND_MIXED: assert property (stepRise && !holdHome && resNow != 2'h0
      && offMode_reg == 2'h1 |=> mixedA_reg && mixedB_reg)
      else $error("grounded mode not mixed");
   AST_FAULT_OFF: assert property (holdHome |=> sourceGateA == 2'h0
      && sinkGateA == 2'h0 && sourceGateB == 2'h0 && sinkGateB == 2'h0)
      else $error("bridge on during fault or reset");
endmodule

// ===== core/mst_wind_if.sv
// Link between the translator and one winding chopper
`timescale 1ns/10ps
interface mst_wind_if;
   logic        en;
   logic        mixed;
   logic        pol;
   logic        trip;
   logic [15:0] offCyc;
   logic [15:0] slowCyc;
   logic [1:0]  hs;
   logic [1:0]  ls;

   modport ctl  (output en, mixed, pol, trip, offCyc, slowCyc, input hs, ls);
   modport chop (input en, mixed, pol, trip, offCyc, slowCyc, output hs, ls);
endinterface

// ===== tb/mst_step_ctl.sv
// Controller model issuing step pulses with minimum phase widths
`timescale 1ns/10ps
module mst_step_ctl #(
   parameter int PHASE_CYC = 250
) (
   input  wire logic clk,
   input  wire logic go,
   output logic      stepPin,
   output logic      busy
);
   int cnt = 0;

   // One pulse per request, high then low for PHASE_CYC cycles each
   always @(posedge clk) begin
      if (cnt != 0) begin
         cnt <= cnt - 1;
      end else if (go) begin
         cnt <= 2 * PHASE_CYC;
      end
   end

   // Both phases last at least 1 us at 250 MHz
   assign stepPin = (cnt > PHASE_CYC);
   assign busy    = (cnt != 0) || go;
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the microstep translator
`timescale 1ns/10ps
module testbench;
   logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, rerr, stepPin, busy, go = 1'b0;
   logic        dirPin = 1'b1, resLo = 1'b0, resHi = 1'b0, trn = 1'b0, oen = 1'b0;
   logic        thermal_shutdown = 1'b0, oc = 1'b0, undervoltage_lockout = 1'b0, tripA = 1'b0, tripB = 1'b0;
   logic [1:0]  srcA, snkA, srcB, snkB;
   logic [7:0]  dacA, dacB;
   logic        polA, polB, mixA, mixB;
   int          fail_count = 0, num_checks = 0, cycles = 0;

   mst_translator #(.OFF_CYCLES(64)) i_mst_translator (.clk(clk), .resetn(resetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .stepPin(stepPin),
      .dirPin(dirPin), .resolutionSelLo(resLo), .resolutionSelHi(resHi),
      .translatorResetN(trn), .outputEnableN(oen), .thermalShutdown(thermal_shutdown),
      .overcurrent(oc), .undervoltageLockout(undervoltage_lockout), .senseTripA(tripA),
      .senseTripB(tripB), .sourceGateA(srcA), .sinkGateA(snkA), .sourceGateB(srcB),
      .sinkGateB(snkB), .dacLevelA(dacA), .dacLevelB(dacB), .polarityA(polA),
      .polarityB(polB), .mixedDecayA(mixA), .mixedDecayB(mixB));
   mst_step_ctl i_mst_step_ctl (.clk(clk), .go(go), .stepPin(stepPin), .busy(busy));

   // 250 MHz clock and a hang guard well past the expected run
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
         fail_count++;
      end
   endtask

   // One APB transfer; caller enters just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chkpos(input logic [5:0] e);
      apb(1'b0, mst_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rdat[5:0]), 32'(e));
   endtask

   // Direction and selects set one edge before the pulse rises
   task automatic step(input logic d, input logic [1:0] r);
      dirPin <= d;
      {resHi, resLo} <= r;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
      cyc(4);
   endtask

   task automatic t_reset;
      chk({srcA, snkA, srcB, snkB, dacA, dacB}, 32'h0000b4b4);
      chk({polA, polB, mixA, mixB}, 32'hf);
      apb(1'b0, mst_pkg::ADDR_LEVEL, 32'h0);
      chk(rdat, 32'h0003b4b4);
      apb(1'b0, mst_pkg::ADDR_CTRL, 32'h0);
      chk(rdat, 32'(mst_pkg::CTRL_RST));
      apb(1'b1, mst_pkg::ADDR_OFFUS, 32'h14);
      apb(1'b0, mst_pkg::ADDR_OFFUS, 32'h0);
      chk(rdat, 32'h14);
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(rerr), 32'h1);
      chk(rdat, 32'h0);
      $display("test reset done");
   endtask

   // Home drives leg0 to leg1; a trip must drop the leg0 source
   task automatic t_chop;
      trn <= 1'b1;
      // No sleep pin here; a settle wait comes before any step
      cyc(300);
      chk(32'({srcA, snkA}), 32'h6);
      tripA <= 1'b1;
      cyc(6);
      chk(32'(srcA[0]), 32'h0);
      tripA <= 1'b0;
      oen <= 1'b1;
      cyc(4);
      chk(32'({srcA, snkA, srcB, snkB}), 32'h0);
      oen <= 1'b0;
      $display("test chop done");
   endtask

   task automatic t_steps;
      logic [5:0] e;
      logic [5:0] inc[4];
      inc = '{mst_pkg::INC_FULL, mst_pkg::INC_HALF, mst_pkg::INC_QUARTER,
              mst_pkg::INC_SIXTEENTH};
      e = mst_pkg::HOME_POS;
      for (int k = 0; k < 8; k++) begin
         step(k < 4, 2'(k % 4));
         e = (k < 4) ? e + inc[k % 4] : e - inc[k % 4];
         if (k == 0) chk(32'({mixB, mixA}), 32'h0);
         chkpos(e);
         chk(32'(rdat[11:10]), 32'(k % 4));
         if (k == 0) begin
            // Slow decay trip: source off, both sinks on
            tripA <= 1'b1;
            cyc(6);
            chk(32'({srcA, snkA}), 32'h3);
            tripA <= 1'b0;
         end
      end
      $display("test steps done");
   endtask

   task automatic t_modes;
      {resHi, resLo} <= mst_pkg::RES_HALF;
      dirPin <= 1'b0;
      cyc(20);
      chkpos(mst_pkg::HOME_POS);
      chk(32'(rdat[11:10]), 32'(mst_pkg::RES_SIXTEENTH));
      step(1'b1, mst_pkg::RES_HALF);
      chk(32'({mixB, mixA}), 32'h2);
      // Winding A at its crest, winding B at its zero crossing
      chk(32'({polA, polB, dacA, dacB}), 32'h2ff00);
      apb(1'b1, mst_pkg::ADDR_CTRL, 32'(mst_pkg::OFFM_GROUND));
      step(1'b1, mst_pkg::RES_HALF);
      chk(32'({mixB, mixA}), 32'h3);
      step(1'b1, mst_pkg::RES_FULL);
      chk(32'({mixB, mixA}), 32'h0);
      chkpos(6'h28);
      // Resistor mode: full step decay is automatic; off the full grid on purpose
      apb(1'b1, mst_pkg::ADDR_CTRL, 32'(mst_pkg::OFFM_RESISTOR));
      step(1'b1, mst_pkg::RES_SIXTEENTH);
      step(1'b1, mst_pkg::RES_FULL);
      chk(32'({mixB, mixA}), 32'h1);
      chkpos(6'h39);
      $display("test modes done");
   endtask

   task automatic t_faults;
      for (int i = 0; i < 3; i++) begin
         {undervoltage_lockout, oc, thermal_shutdown} <= 3'(1 << i);
         cyc(8);
         chkpos(mst_pkg::HOME_POS);
         chk(32'({srcA, snkA, srcB, snkB}), 32'h0);
         {undervoltage_lockout, oc, thermal_shutdown} <= 3'h0;
         cyc(8);
         step(1'b1, mst_pkg::RES_FULL);
      end
      trn <= 1'b0;
      step(1'b1, mst_pkg::RES_FULL);
      chkpos(mst_pkg::HOME_POS);
      chk(32'({srcA, snkA, srcB, snkB}), 32'h0);
      $display("test faults done");
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Reset for five cycles, then the scenarios in order
   initial begin
      cyc(5);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset;
      t_chop;
      t_steps;
      t_modes;
      t_faults;
      report_and_stop;
   end
endmodule
